//--- sss_pkg.sv
/*
   constants for the synchronous sram select, write and sleep control.
   assumes one 125 MHz clock and synchronous active-high reset.
*/
// Summary of operation
// R01 - selected only when first enable low, second high, third low.
// R02 - full-width write on global write low, or gate low with all lanes low.
// R03 - after a write, data outputs stay high-z until a new strobed read.
// R04 - controller must deselect the device before raising sleep request.
// R05 - on leaving sleep, data pins stay high-z until a later read.
// R06 - gated byte write stores only lanes whose lane write input is low.
package sss_pkg;
   localparam int LANES = 4;
   localparam int LANE_BITS = 9;
   localparam int ADDR_BITS = 6;
   localparam int READ_LATENCY = 2;
   localparam logic RST_DRIVE = 1'b0;
endpackage

//--- sss_mem.sv
/*
   byte-lane writable memory with registered read data.
   assumes writes and reads are synchronous to clock.
*/
`timescale 1ns/1ps
module sss_mem #(
   parameter int LANES = sss_pkg::LANES,
   parameter int LANE_BITS = sss_pkg::LANE_BITS,
   parameter int ADDR_BITS = sss_pkg::ADDR_BITS
) (
   input wire logic clock,
   input wire logic [ADDR_BITS-1:0] addr,
   input wire logic [LANES-1:0] lane_we,
   input wire logic [LANES*LANE_BITS-1:0] wdata,
   output logic [LANES*LANE_BITS-1:0] rdata
);
   logic [LANES*LANE_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];

   always_ff @(posedge clock)
   begin
      for (int i = 0; i < LANES; i++)
      begin
         if (lane_we[i])
         begin
            mem[addr][i*LANE_BITS +: LANE_BITS] <=
               wdata[i*LANE_BITS +: LANE_BITS]; // [R06]
         end
      end
      rdata <= mem[addr];
   end
endmodule

//--- sss_ctrl.sv
/*
   bus-side control of a pipelined synchronous sram: chip select decode,
   byte and full writes, output drive control and sleep.
   assumes all inputs are synchronous to clock; the controller keeps the
   device deselected while raising sleep_request.
*/
`timescale 1ns/1ps
module sss_ctrl #(
   parameter int LANES = sss_pkg::LANES,
   parameter int LANE_BITS = sss_pkg::LANE_BITS,
   parameter int ADDR_BITS = sss_pkg::ADDR_BITS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_BITS-1:0] addr,
   input wire logic pipeline_select_n,
   input wire logic depth_expand_select_high,
   input wire logic depth_expand_select_n,
   input wire logic processor_addr_strobe_n,
   input wire logic controller_addr_strobe_n,
   input wire logic global_write_n,
   input wire logic byte_write_gate_n,
   input wire logic [LANES-1:0] lane_write_n,
   input wire logic sleep_request,
   input wire logic [LANES*LANE_BITS-1:0] data_in,
   output logic [LANES*LANE_BITS-1:0] data_out,
   output logic data_oe,
   output logic selected,
   output logic full_write,
   output logic sleeping
);
   // read pipe taps stage READ_LATENCY-2, so two stages is the floor
   if (LANES < 1 || LANE_BITS < 1 || ADDR_BITS < 1 ||
      sss_pkg::READ_LATENCY < 2)
   begin
      $error("sss_ctrl: unsupported parameter values");
   end

   typedef enum logic [1:0] {SSS_IDLE, SSS_READ, SSS_WRITE, SSS_SLEEP}
      sss_state_t;

   sss_state_t state;
   sss_state_t next_state;
   logic strobe;
   logic is_write;
   logic [LANES-1:0] lane_we;
   logic [LANES*LANE_BITS-1:0] rdata;
   logic [sss_pkg::READ_LATENCY-1:0] read_pipe;

   function automatic logic sss_sel(input logic a_n, input logic b,
      input logic c_n);
      return !a_n && b && !c_n; // [R01]
   endfunction

   assign strobe = !processor_addr_strobe_n || !controller_addr_strobe_n;
   assign selected = sss_sel(pipeline_select_n, depth_expand_select_high,
      depth_expand_select_n); // [R01]
   assign full_write = !global_write_n ||
      (!byte_write_gate_n && (lane_write_n == '0)); // [R02]
   assign is_write = !global_write_n || !byte_write_gate_n;
   assign sleeping = (state == SSS_SLEEP);

   // only a controller strobe may start a write; processor strobe reads
   always_comb
   begin
      lane_we = '0;
      if (selected && !controller_addr_strobe_n && !sleep_request)
      begin
         if (!global_write_n)
            lane_we = '1; // [R02]
         else if (!byte_write_gate_n)
            lane_we = ~lane_write_n; // [R06]
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         SSS_SLEEP:
            if (!sleep_request)
               next_state = SSS_IDLE; // [R05]
         default:
            if (sleep_request && !selected)
               next_state = SSS_SLEEP; // [R04]
            else if (selected && strobe && !sleep_request)
               next_state = (|lane_we) ? SSS_WRITE : SSS_READ;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         state <= SSS_IDLE;
      else
         state <= next_state;
   end

   // read pipe: strobed read, not a write, not during sleep
   always_ff @(posedge clock)
   begin
      if (rst || state == SSS_SLEEP || sleep_request)
         read_pipe <= '0; // [R05]
      else
         read_pipe <= {read_pipe[sss_pkg::READ_LATENCY-2:0],
            selected && strobe && !(|lane_we) &&
            (processor_addr_strobe_n ? !is_write : 1'b1)};
   end

   // drive only for reads; writes and sleep exit leave bus high-z
   always_ff @(posedge clock)
   begin
      if (rst)
         data_oe <= sss_pkg::RST_DRIVE;
      else if (|lane_we || state == SSS_SLEEP)
         data_oe <= 1'b0; // [R03] [R05]
      else if (read_pipe[sss_pkg::READ_LATENCY-2])
         data_oe <= 1'b1;
      else if (selected && strobe)
         data_oe <= data_oe;
      else if (!selected && strobe)
         data_oe <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         data_out <= '0;
      else if (read_pipe[sss_pkg::READ_LATENCY-2])
         data_out <= rdata;
   end

   sss_mem #(
      .LANES(LANES),
      .LANE_BITS(LANE_BITS),
      .ADDR_BITS(ADDR_BITS)
   ) u_mem (
      .clock(clock),
      .addr(addr),
      .lane_we(lane_we),
      .wdata(data_in),
      .rdata(rdata)
   );

   // a deselected cycle neither writes nor starts a read
   chk_select_decode: assert property ( // [R01]
      @(posedge clock) disable iff (rst)
      !selected |-> (lane_we == '0) ##1 !read_pipe[0])
      else $error("deselected cycle acted");

   chk_full_lanes: assert property ( // [R02]
      @(posedge clock) disable iff (rst)
      (selected && !controller_addr_strobe_n && !sleep_request &&
      full_write) |-> (lane_we == '1))
      else $error("full write lanes");

   chk_full_decode: assert property ( // [R02]
      @(posedge clock) disable iff (rst)
      !global_write_n |-> full_write)
      else $error("global write not full width");

   chk_proc_read_only: assert property ( // [R02]
      @(posedge clock) disable iff (rst)
      (!processor_addr_strobe_n && controller_addr_strobe_n)
      |-> (lane_we == '0))
      else $error("processor strobe wrote");

   chk_write_hiz: assert property ( // [R03]
      @(posedge clock) disable iff (rst)
      (|lane_we) |=> (!data_oe && !read_pipe[0]))
      else $error("bus driven after write");

   // high-z is only left through a read in the pipe
   chk_hiz_hold: assert property ( // [R03]
      @(posedge clock) disable iff (rst)
      (!data_oe && !read_pipe[0]) |=> !data_oe)
      else $error("bus driven without read");

   chk_read_drive: assert property ( // [R03]
      @(posedge clock) disable iff (rst)
      (read_pipe[0] && (lane_we == '0) && !sleeping) |=> data_oe)
      else $error("read data not driven");

   chk_sleep_entry: assert property ( // [R04]
      @(posedge clock) disable iff (rst)
      (!sleeping && sleep_request && selected) |=> !sleeping)
      else $error("sleep entered while selected");

   chk_sleep_taken: assert property ( // [R04]
      @(posedge clock) disable iff (rst)
      (!sleeping && sleep_request && !selected) |=> sleeping)
      else $error("sleep request not taken");

   chk_sleep_refuse: assert property ( // [R04]
      @(posedge clock) disable iff (rst)
      sleep_request |-> (lane_we == '0))
      else $error("write during sleep request");

   chk_sleep_hiz: assert property ( // [R05]
      @(posedge clock) disable iff (rst)
      (sleeping ##1 !sleeping) |-> !data_oe [*2])
      else $error("bus driven leaving sleep");

   chk_sleep_quiet: assert property ( // [R05]
      @(posedge clock) disable iff (rst)
      sleeping |=> !data_oe)
      else $error("bus driven in sleep");

   chk_sleep_exit: assert property ( // [R05]
      @(posedge clock) disable iff (rst)
      (sleeping && !sleep_request) |=> !sleeping)
      else $error("sleep not left");

   chk_lane_mask: assert property ( // [R06]
      @(posedge clock) disable iff (rst)
      (global_write_n && !byte_write_gate_n && selected &&
      !controller_addr_strobe_n && !sleep_request)
      |-> (lane_we == ~lane_write_n))
      else $error("lane mask");
endmodule

//--- sss_host.sv
/*
   host stub that turns a small command into sram bus pins.
   assumes the bench changes its command just after a rising edge.
*/
`timescale 1ns/1ps
module sss_host (
   input wire logic [2:0] op,
   input wire logic [2:0] en,
   input wire logic [sss_pkg::LANES-1:0] lanes,
   input wire logic sleep,
   output logic pipeline_select_n,
   output logic depth_expand_select_high,
   output logic depth_expand_select_n,
   output logic processor_addr_strobe_n,
   output logic controller_addr_strobe_n,
   output logic global_write_n,
   output logic byte_write_gate_n,
   output logic [sss_pkg::LANES-1:0] lane_write_n,
   output logic sleep_request
);
   // ops: 1 read by processor strobe, 2 controller read, 3 full, 4 byte
   always_comb
   begin
      // sleep forces a deselect, whatever the bench asks for
      {pipeline_select_n, depth_expand_select_high,
         depth_expand_select_n} = en | {sleep, 2'b00};
      processor_addr_strobe_n = op != 3'd1;
      controller_addr_strobe_n = !(op inside {3'd2, 3'd3, 3'd4});
      global_write_n = op != 3'd3;
      byte_write_gate_n = op != 3'd4;
      lane_write_n = ~lanes;
      sleep_request = sleep;
   end
endmodule

//--- sss_ctrl_test.sv
/*
   self-checking bench for sss_ctrl with a host stub.
   assumes the 8 ns clock and reads answering two edges after the strobe.
*/
`timescale 1ns/1ps
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
   $display("ERROR %0t mismatch", $time); end end
module sss_ctrl_test;
   localparam int W = sss_pkg::LANES * sss_pkg::LANE_BITS;
   localparam int B = sss_pkg::LANE_BITS;
   logic clock = 0, rst = 1, sleep = 0;
   logic [2:0] op = 0, en = 3'b010;
   logic [1:0] p = 0;
   logic [3:0] lanes = 0, lane_write_n;
   logic [5:0] addr = 0;
   logic [W-1:0] data_in = 0, data_out, mem [64], q [$];
   logic pipeline_select_n, depth_expand_select_high, depth_expand_select_n;
   logic processor_addr_strobe_n, controller_addr_strobe_n, global_write_n;
   logic byte_write_gate_n, sleep_request, data_oe, selected, full_write;
   logic sleeping;
   int fail_count = 0, checks = 0;
   always #4 clock = ~clock;
   sss_host host (.op, .en, .lanes, .sleep, .pipeline_select_n,
      .depth_expand_select_high, .depth_expand_select_n,
      .processor_addr_strobe_n, .controller_addr_strobe_n, .global_write_n,
      .byte_write_gate_n, .lane_write_n, .sleep_request);
   sss_ctrl dut (.clock, .rst, .addr, .pipeline_select_n,
      .depth_expand_select_high, .depth_expand_select_n,
      .processor_addr_strobe_n, .controller_addr_strobe_n, .global_write_n,
      .byte_write_gate_n, .lane_write_n, .sleep_request, .data_in,
      .data_out, .data_oe, .selected, .full_write, .sleeping);
   // read taken at an edge is answered at the next edge
   always @(posedge clock)
      p <= {p[0], op inside {3'd1, 3'd2} && en == 3'b010 && !sleep};
   always @(negedge clock)
      if (p[1])
      begin
         `CMP(data_oe, 1'b1)
         `CMP(data_out, q.pop_front())
      end
   task automatic go(input logic [2:0] o, input logic [5:0] a,
      input logic [3:0] l);
      @(posedge clock);
      #1 op = o;
      addr = a;
      lanes = l;
      data_in = W'({$urandom, $urandom});
      if (o == 3'd3)
         mem[a] = data_in;
      for (int i = 0; i < 4; i++)
         if (o == 3'd4 && l[i])
            mem[a][B*i +: B] = data_in[B*i +: B];
      if (o inside {3'd1, 3'd2} && en == 3'b010 && !sleep)
         q.push_back(mem[a]);
   endtask
   task automatic summarize;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // about 150 cycles expected; the limit leaves ample margin
   initial
   begin
      #20000 fail_count++;
      summarize();
   end
   initial
   begin
      void'($urandom(42925));
      repeat (12) @(posedge clock);
      #1 rst = 0;
      for (int e = 0; e < 8; e++)
      begin
         @(posedge clock);
         #1 en = 3'(e);
         #1 `CMP(selected, e == 2)
      end
      @(posedge clock);
      #1 en = 3'b010;
      for (int a = 0; a < 8; a++)
      begin
         go(3, 6'(a), 4'(a));
         #1 `CMP(full_write, 1'b1)
      end
      go(4, 1, 4'hF);
      #1 `CMP(full_write, 1'b1)
      go(4, 2, 4'h5);
      #1 `CMP(full_write, 1'b0)
      for (int a = 0; a < 8; a++)
         go(3'(1 + a % 2), 6'(a), 0);
      // let the last answer stand before a write takes the bus away
      go(0, 0, 0);
      go(3, 3, 0);
      repeat (3)
      begin
         go(0, 0, 0);
         #1 `CMP(data_oe, 1'b0)
      end
      // drive the bus before sleep so leaving it proves high-z
      go(2, 5, 0);
      go(0, 0, 0);
      @(posedge clock);
      #1 sleep = 1;
      go(1, 4, 0);
      go(0, 0, 0);
      #1 `CMP(sleeping, 1'b1)
      @(posedge clock);
      #1 sleep = 0;
      repeat (3) go(0, 0, 0);
      #1 `CMP(sleeping, 1'b0)
      `CMP(data_oe, 1'b0)
      repeat (30)
      begin
         go(3'($urandom_range(4, 1)), 6'($urandom_range(7)), 4'($urandom));
         repeat (2) go(0, 0, 0);
      end
      summarize();
   end
endmodule
